// ---- logic/pcp_consts.vh ----
// Purpose: constants of the parallel configuration port
// Assumes: 40 MHz system clock
// Notes:   definitions only
`ifndef PCP_CONSTS_VH
`define PCP_CONSTS_VH

// System clock rate, in kHz
`define PCP_CLK_KHZ 40000
// Master config_clock half period, ns
`define PCP_MCLK_HALF_NS 100
// Half period in cycles, rounded down
`define PCP_MCLK_HALF_CYC ((`PCP_MCLK_HALF_NS * `PCP_CLK_KHZ) / 1000000)
// Last divider count of a master half period, sized to the divider
`define PCP_MCLK_DIV_LAST 8'h03

// Mode codes on mode_select_pins
`define PCP_MODE_MPAR 3'h3
`define PCP_MODE_SPAR 3'h7
`define PCP_MODE_JTAG 3'h5

// Width code in the first written word
`define PCP_WCODE_LSB 0
`define PCP_W8 2'h0
`define PCP_W16 2'h1
`define PCP_W32 2'h2

// Port states
`define PCP_ST_INIT 3'h0
`define PCP_ST_DETECT 3'h1
`define PCP_ST_ACTIVE 3'h2
`define PCP_ST_ABORT 3'h3
`define PCP_ST_IDLE 3'h4

// Reset values
`define PCP_RST_WORD 32'h00000000
`define PCP_RST_MODE 3'h0
`define PCP_RST_DIV 8'h00

`endif

// ---- logic/pcp_parallel_config_port.v ----
// Purpose: parallel configuration and readback port
// Assumes: all pins asynchronous to clk; config_clock far below clk/4
// Notes:   programResetN clears asynchronously, release is synchronised
`timescale 1ns/1ps
`include "pcp_consts.vh"

// Summary of operation
// RULE1: Two-way data bus for loading and readback, 8, 16 or 32 bits wide.
// RULE2: Bus width is found from the first written word, not an input.
// RULE3: Master mode drives config_clock; slave mode takes it as an input.
// RULE4: Mode comes from the three mode_select_pins.
// RULE5: config_clock clocks transfers in every mode but boundary scan.
// RULE6: Each word moves on the rising edge of config_clock.
// RULE7: busy is high while no readback word is ready.
// RULE8: done is low until configuration completes, then high.
// RULE9: Before mode sampling, a low init_status_n holds configuration off.
// RULE10: After sampling, init_status_n is pulled low on a CRC error.
// RULE11: With upset detection on, a readback CRC error pulls it low.
// RULE12: program_reset_n low resets the whole port asynchronously.
// RULE13: chip_select_n low enables the bus, high disables it.
// RULE14: direction_select low makes inputs, high drives the bus.
// RULE15: direction change while selected causes a transfer abort.
// RULE16: chain_select_out_n selects the next device of a chain.
// RULE17: Single master, single slave, shared bus and ganged use.
// RULE18: Abort stops bus data until chip select is released.
module pcp_parallel_config_port (
    input  wire        clk,               // System clock
    input  wire        nrst,              // Synchronous reset, low
    input  wire        programResetN,     // Full reset pin, low
    input  wire [2:0]  modeSelectPins,    // Mode pins
    input  wire        configClockIn,     // config_clock pin level
    output reg         configClockOut,    // config_clock drive
    output reg         configClockOe,     // config_clock enable
    input  wire [31:0] dataIn,            // Data pins level
    output reg  [31:0] dataOut,           // Data pins drive
    output reg         dataOe,            // Data pins enable
    input  wire        chipSelectN,       // Chip select, low
    input  wire        directionSelect,   // 1 read, 0 write
    output reg         busy,              // Readback not ready
    output reg         done,              // Configured
    input  wire        initStatusIn,      // init_status_n level
    output reg         initStatusOut,     // init_status_n drive
    output reg         initStatusOe,      // init_status_n pull
    output reg         chainSelectOutN,   // Next device select
    input  wire        upsetDetectEn,     // Upset detection on
    output reg  [31:0] cfgWord,           // Written word
    output reg         cfgValid,          // Written word pulse
    output reg  [1:0]  busWidth,          // Detected width code
    input  wire        cfgComplete,       // Loading complete
    input  wire        cfgCrcError,       // Load CRC error
    input  wire        rbCrcError,        // Readback CRC error
    input  wire [31:0] rbWord,            // Readback word
    input  wire        rbValid,           // Readback word valid
    output reg         rbTake             // Readback word taken
);

    // Release of the pin reset is synchronised
    reg [1:0] progSync;
    always @(posedge clk or negedge programResetN) begin
        if (!programResetN) begin // RULE12
            progSync <= 2'h0;
        end else begin
            progSync <= {progSync[0], 1'b1};
        end
    end
    wire runOk = nrst & progSync[1];

    // Every pin but programResetN passes two flops before any logic reads it
    wire [31:0] dataSync;
    wire [2:0]  modeSync;
    wire        clkPin;
    wire        csN;
    wire        dirSel;
    wire        initPin;

    pcp_sync2 #(
        .WIDTH(32)
    ) i_dataSync (
        .clk    (clk),
        .pinIn  (dataIn),
        .syncOut(dataSync)
    );

    pcp_sync2 #(
        .WIDTH(3)
    ) i_modeSync (
        .clk    (clk),
        .pinIn  (modeSelectPins),
        .syncOut(modeSync)
    );

    pcp_sync2 #(
        .WIDTH(1)
    ) i_clkSync (
        .clk    (clk),
        .pinIn  (configClockIn),
        .syncOut(clkPin)
    );

    pcp_sync2 #(
        .WIDTH(1)
    ) i_csSync (
        .clk    (clk),
        .pinIn  (chipSelectN),
        .syncOut(csN)
    );

    pcp_sync2 #(
        .WIDTH(1)
    ) i_dirSync (
        .clk    (clk),
        .pinIn  (directionSelect),
        .syncOut(dirSel)
    );

    pcp_sync2 #(
        .WIDTH(1)
    ) i_initSync (
        .clk    (clk),
        .pinIn  (initStatusIn),
        .syncOut(initPin)
    );

    reg [2:0] state;
    reg [2:0] next_state;
    reg [2:0] mode;
    reg       clkPinPrev;
    reg       csPrevN;
    reg       dirPrev;
    reg [7:0] divCnt;
    reg       crcErr;
    reg [31:0] rdData;
    reg       rdFull;

    wire isMaster = (mode == `PCP_MODE_MPAR);
    wire isSlave  = (mode == `PCP_MODE_SPAR);
    wire parMode  = isMaster | isSlave;

    // Master clock rises when the divider wraps with output low
    wire divWrap = (divCnt == `PCP_MCLK_DIV_LAST);
    wire mRise   = isMaster & divWrap & ~configClockOut;
    wire sRise   = isSlave & clkPin & ~clkPinPrev;
    // Boundary-scan mode never forms a transfer edge
    wire xRise   = mRise | sRise; // RULE5 RULE6

    wire selNow  = ~csN & ~csPrevN; // RULE13
    // Direction flip while selected
    wire dirFlip = selNow & (dirSel != dirPrev); // RULE15

    wire wrXfer  = xRise & ~csN & ~dirSel; // RULE14
    wire rdXfer  = xRise & ~csN & dirSel & rdFull;

    // Mask to the active width
    reg [31:0] wMask;
    always @* begin
        case (busWidth)
            `PCP_W8: begin
                wMask = 32'h000000ff;
            end
            `PCP_W16: begin
                wMask = 32'h0000ffff;
            end
            default: begin
                wMask = 32'hffffffff;
            end
        endcase
    end

    always @* begin
        next_state = state;
        case (state)
            `PCP_ST_INIT: begin
                if (initPin) begin // RULE9
                    if (modeSync == `PCP_MODE_MPAR ||
                        modeSync == `PCP_MODE_SPAR) begin // RULE4
                        next_state = `PCP_ST_DETECT;
                    end else begin
                        next_state = `PCP_ST_IDLE;
                    end
                end
            end
            `PCP_ST_DETECT: begin
                if (dirFlip) begin
                    next_state = `PCP_ST_ABORT;
                end else if (wrXfer) begin
                    next_state = `PCP_ST_ACTIVE;
                end
            end
            `PCP_ST_ACTIVE: begin
                if (dirFlip) begin
                    next_state = `PCP_ST_ABORT;
                end
            end
            `PCP_ST_ABORT: begin
                if (csN) begin // RULE18
                    next_state = `PCP_ST_ACTIVE;
                end
            end
            `PCP_ST_IDLE: begin
                next_state = `PCP_ST_IDLE;
            end
            default: begin
                next_state = `PCP_ST_INIT;
            end
        endcase
    end

    always @(posedge clk or negedge programResetN) begin
        if (!programResetN) begin // RULE12
            state           <= `PCP_ST_INIT;
            mode            <= `PCP_RST_MODE;
            clkPinPrev      <= 1'b0;
            csPrevN         <= 1'b1;
            dirPrev         <= 1'b0;
            divCnt          <= `PCP_RST_DIV;
            configClockOut  <= 1'b0;
            configClockOe   <= 1'b0;
            dataOut         <= `PCP_RST_WORD;
            dataOe          <= 1'b0;
            busy            <= 1'b1;
            done            <= 1'b0;
            initStatusOut   <= 1'b0;
            initStatusOe    <= 1'b0;
            chainSelectOutN <= 1'b1;
            crcErr          <= 1'b0;
            cfgWord         <= `PCP_RST_WORD;
            cfgValid        <= 1'b0;
            busWidth        <= `PCP_W8;
            rdData          <= `PCP_RST_WORD;
            rdFull          <= 1'b0;
            rbTake          <= 1'b0;
        end else if (!runOk) begin
            state           <= `PCP_ST_INIT;
            mode            <= `PCP_RST_MODE;
            clkPinPrev      <= 1'b0;
            csPrevN         <= 1'b1;
            dirPrev         <= 1'b0;
            divCnt          <= `PCP_RST_DIV;
            configClockOut  <= 1'b0;
            configClockOe   <= 1'b0;
            dataOut         <= `PCP_RST_WORD;
            dataOe          <= 1'b0;
            busy            <= 1'b1;
            done            <= 1'b0;
            initStatusOut   <= 1'b0;
            initStatusOe    <= 1'b0;
            chainSelectOutN <= 1'b1;
            crcErr          <= 1'b0;
            cfgWord         <= `PCP_RST_WORD;
            cfgValid        <= 1'b0;
            busWidth        <= `PCP_W8;
            rdData          <= `PCP_RST_WORD;
            rdFull          <= 1'b0;
            rbTake          <= 1'b0;
        end else begin
            state      <= next_state;
            clkPinPrev <= clkPin;
            csPrevN    <= csN;
            dirPrev    <= dirSel;

            // Mode is caught once, when init is released
            if (state == `PCP_ST_INIT && initPin) begin
                mode <= modeSync; // RULE4
            end

            // Master drives the clock, slave only listens
            configClockOe <= isMaster; // RULE3
            if (isMaster) begin
                if (divWrap) begin
                    divCnt         <= `PCP_RST_DIV;
                    configClockOut <= ~configClockOut;
                end else begin
                    divCnt <= divCnt + 8'h01;
                end
            end else begin
                divCnt         <= `PCP_RST_DIV;
                configClockOut <= 1'b0;
            end

            // First written word carries the width code
            cfgValid <= 1'b0;
            if (state == `PCP_ST_DETECT && wrXfer && !dirFlip) begin
                case (dataSync[`PCP_WCODE_LSB+1:`PCP_WCODE_LSB])
                    `PCP_W16: begin
                        busWidth <= `PCP_W16; // RULE2
                    end
                    `PCP_W32: begin
                        busWidth <= `PCP_W32; // RULE2
                    end
                    default: begin
                        busWidth <= `PCP_W8; // RULE2
                    end
                endcase
            end else if (state == `PCP_ST_ACTIVE && wrXfer && !dirFlip) begin
                cfgWord  <= dataSync & wMask; // RULE1 RULE6
                cfgValid <= 1'b1;
            end

            // One word of readback is held ready for the next edge
            rbTake <= 1'b0;
            if (state == `PCP_ST_ACTIVE && rdXfer && !dirFlip) begin
                rdFull <= 1'b0; // RULE6
            end else if (!rdFull && rbValid && !rbTake) begin
                rdData <= rbWord & wMask; // RULE1
                rdFull <= 1'b1;
                rbTake <= 1'b1;
            end

            // Bus is driven only selected, reading and not aborted
            dataOe  <= (next_state == `PCP_ST_ACTIVE) && !csN
                       && dirSel && !dirFlip; // RULE13 RULE14 RULE18
            dataOut <= rdData;
            busy    <= ~rdFull | csN | ~dirSel; // RULE7

            if (cfgComplete && parMode) begin
                done <= 1'b1; // RULE8
            end
            // Chain select passes on once this device is loaded
            chainSelectOutN <= ~(done & parMode); // RULE16 RULE17

            // Error flags are sticky; a set loses only to a reset
            if (cfgCrcError && !done) begin
                crcErr <= 1'b1; // RULE10
            end else if (rbCrcError && upsetDetectEn) begin
                crcErr <= 1'b1; // RULE11
            end
            // Pin is an input until the mode has been caught
            initStatusOut <= 1'b0;
            initStatusOe  <= (state != `PCP_ST_INIT) & crcErr; // RULE9 RULE10
        end
    end

endmodule

// Two flops per pin; nothing but the second one is read outside
module pcp_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             clk,     // System clock
    input  wire [WIDTH-1:0] pinIn,   // Level from outside clk
    output reg  [WIDTH-1:0] syncOut  // Level safe to use on clk
);

    reg [WIDTH-1:0] meta;

    always @(posedge clk) begin
        meta    <= pinIn;
        syncOut <= meta;
    end

endmodule

// ---- tb/pcp_props.sv ----
// Purpose: port checks of pcp_parallel_config_port
// Assumes: either reset disables every check
// Notes:   bound after the module
`timescale 1ns/1ps
module pcp_props (
    input wire clk,             // Clock
    input wire nrst,            // Reset
    input wire programResetN,   // Pin reset
    input wire chipSelectN,     // Select
    input wire directionSelect, // Direction
    input wire dataOe,          // Bus drive
    input wire done,            // Configured
    input wire chainSelectOutN, // Chain select
    input wire cfgComplete,     // Load end
    input wire cfgValid,        // Word pulse
    input wire rbTake,          // Word taken
    input wire initStatusOe,    // Init pull
    input wire initStatusOut,   // Init drive
    input wire configClockOe,   // Clock enable
    input wire configClockOut   // Clock drive
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst || !programResetN);
    a_done_sticky: assert property (done |=> done)
        else $error("done dropped");
    a_done_cause: assert property ($rose(done) |-> $past(cfgComplete))
        else $error("done without completion");
    a_chain_after: assert property ($fell(chainSelectOutN) |-> $past(done))
        else $error("chain select before done");
    a_word_pulse: assert property (cfgValid |=> !cfgValid)
        else $error("two words for one edge");
    a_take_pulse: assert property (rbTake |=> !rbTake)
        else $error("readback take too long");
    a_bus_desel: assert property (chipSelectN [*5] |-> !dataOe)
        else $error("bus driven while deselected");
    a_bus_write: assert property (!directionSelect [*5] |-> !dataOe)
        else $error("bus driven while writing");
    a_clock_idle: assert property (!configClockOe |-> !configClockOut)
        else $error("clock driven when disabled");
    a_init_drain: assert property (initStatusOe |-> !initStatusOut)
        else $error("init driven high");
    c_write: cover property (cfgValid);
    c_read: cover property (rbTake);
    c_done: cover property ($rose(done));
endmodule
bind pcp_parallel_config_port pcp_props i_props (.clk(clk), .nrst(nrst),
    .programResetN(programResetN), .chipSelectN(chipSelectN),
    .directionSelect(directionSelect), .dataOe(dataOe), .done(done),
    .chainSelectOutN(chainSelectOutN), .cfgComplete(cfgComplete), .cfgValid(cfgValid),
    .rbTake(rbTake), .initStatusOe(initStatusOe), .initStatusOut(initStatusOut),
    .configClockOe(configClockOe), .configClockOut(configClockOut));

// ---- tb/pcp_host_model.sv ----
// Purpose: slave-mode configuration controller
// Assumes: clk is the bench clock, 25 ns
// Notes:   config_clock stands low outside a transfer
`timescale 1ns/1ps
module pcp_host_model (
    input  wire        clk,  // Bench clock
    input  wire [31:0] bus,  // Resolved data pins
    output reg         config_clock, // config_clock drive
    output reg  [31:0] data, // Data drive
    output reg         csN,  // Chip select
    output reg         dir   // Direction
);
    initial begin
        config_clock = 1'b0;
        data = 32'h00000000;
        csN = 1'b1;
        dir = 1'b0;
    end
    // Callers flip dir while selected only to force an abort
    task sel(input logic c, input logic d);
        @(posedge clk);
        csN <= c;
        dir <= d;
    endtask
    task xfer(input logic [31:0] w, output logic [31:0] r);
        @(posedge clk);
        data <= w;
        // Three set-up cycles keep config_clock at eight cycles a period
        repeat (3) @(posedge clk);
        config_clock <= 1'b1;
        r = bus;
        repeat (4) @(posedge clk);
        config_clock <= 1'b0;
        data <= ~w; // Hold over: show no stale value
    endtask
endmodule

// ---- tb/test_parallel_config_port.sv ----
// Purpose: self-checking bench of the parallel configuration port
// Assumes: slave parallel mode, x16 bus; master mode after the pin reset
// Notes:   a queue predicts every written word
`timescale 1ns/1ps
`include "pcp_consts.vh"
module test_parallel_config_port;
    reg          clk = 1'b0;
    reg          nrst = 1'b0;
    reg          progN = 1'b1;
    reg          holdInit = 1'b1;
    reg          cfgComplete = 1'b0;
    reg          cfgCrcError = 1'b0;
    reg          rbValid = 1'b0;
    reg          upsetEn = 1'b0;
    reg          rbCrcErr = 1'b0;
    reg          prevClk = 1'b0;
    reg  [2:0]   mode = `PCP_MODE_SPAR;
    reg  [31:0]  rbWord = 32'h00000000;
    wire [31:0]  hData, dOut, cfgWord, pins;
    wire         hClk, csN, dir, cOut, cOe, dOe, busy, done, iOut, iOe, chainN, cfgValid;
    wire         rbTake;
    wire [1:0]   busWidth;
    integer      seed = 15806, mismatches = 0, num_checks = 0, i, n;
    logic [31:0] expQ[$], w, r;
    assign pins = dOe ? dOut : hData;
    pcp_host_model i_host (.clk(clk), .bus(pins), .config_clock(hClk), .data(hData), .csN(csN),
        .dir(dir));
    pcp_parallel_config_port i_dut (.clk(clk), .nrst(nrst), .programResetN(progN),
        .modeSelectPins(mode), .configClockIn(cOe ? cOut : hClk), .configClockOut(cOut),
        .configClockOe(cOe), .dataIn(pins), .dataOut(dOut), .dataOe(dOe), .chipSelectN(csN),
        .directionSelect(dir), .busy(busy), .done(done), .initStatusIn(!(iOe || holdInit)),
        .initStatusOut(iOut), .initStatusOe(iOe), .chainSelectOutN(chainN),
        .upsetDetectEn(upsetEn), .cfgWord(cfgWord), .cfgValid(cfgValid), .busWidth(busWidth),
        .cfgComplete(cfgComplete), .cfgCrcError(cfgCrcError), .rbCrcError(rbCrcErr),
        .rbWord(rbWord), .rbValid(rbValid), .rbTake(rbTake));
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        forever #12.5 clk = ~clk;
    end
    // An unexpected word meets an empty queue and fails
    always @(posedge clk) begin
        if (cfgValid === 1'b1) begin
            chk("cfgWord", cfgWord, expQ.size() ? expQ.pop_front() : ~cfgWord);
        end
    end
    // Whole run is about 6 us; this bound is generous
    initial begin
        #200000;
        mismatches = mismatches + 1;
        tally_and_finish;
    end
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        i_host.sel(1'b0, 1'b0);
        i_host.xfer(32'h00000001, r);
        chk("initHold", {30'h0, busWidth}, {30'h0, `PCP_W8});
        holdInit <= 1'b0;
        repeat (8) @(posedge clk);
        w = $random(seed);
        i_host.xfer({w[31:2], `PCP_W16}, r);
        chk("busWidth", {30'h0, busWidth}, {30'h0, `PCP_W16});
        for (i = 0; i < 5; i = i + 1) begin
            w = $random(seed);
            expQ.push_back(w & 32'h0000ffff);
            i_host.xfer(w, r);
        end
        $display("test write done");
        i_host.sel(1'b0, 1'b1);
        repeat (6) @(posedge clk);
        chk("abortOe", {31'h0, dOe}, 32'h0);
        i_host.xfer(32'h0000a5a5, r);
        chk("abortBus", r, 32'h0000a5a5);
        i_host.sel(1'b1, 1'b1);
        repeat (4) @(posedge clk);
        i_host.sel(1'b1, 1'b0);
        i_host.sel(1'b0, 1'b0);
        w = $random(seed);
        expQ.push_back(w & 32'h0000ffff);
        i_host.xfer(w, r);
        $display("test abort done");
        i_host.sel(1'b1, 1'b0);
        repeat (4) @(posedge clk);
        i_host.sel(1'b1, 1'b1);
        repeat (4) @(posedge clk);
        i_host.sel(1'b0, 1'b1);
        w = $random(seed);
        rbWord <= w;
        rbValid <= 1'b1;
        for (i = 0; i < 40 && busy !== 1'b0; i = i + 1) @(posedge clk);
        rbValid <= 1'b0;
        chk("busy", {31'h0, busy}, 32'h0);
        i_host.xfer(32'h00000000, r);
        chk("rbData", r, w & 32'h0000ffff);
        @(negedge clk);
        chk("busyAfter", {31'h0, busy}, 32'h1);
        i_host.sel(1'b1, 1'b1);
        repeat (6) @(posedge clk);
        chk("deselOe", {31'h0, dOe}, 32'h0);
        $display("test readback done");
        cfgCrcError <= 1'b1;
        @(posedge clk);
        cfgCrcError <= 1'b0;
        repeat (3) @(posedge clk);
        chk("initPull", {31'h0, iOe}, 32'h1);
        cfgComplete <= 1'b1;
        @(posedge clk);
        cfgComplete <= 1'b0;
        repeat (3) @(posedge clk);
        chk("done", {31'h0, done}, 32'h1);
        chk("chainN", {31'h0, chainN}, 32'h0);
        progN <= 1'b0;
        mode  <= `PCP_MODE_MPAR;
        @(posedge clk);
        #1;
        chk("doneReset", {31'h0, done}, 32'h0);
        @(posedge clk);
        progN <= 1'b1;
        $display("test finish done");
        // Release of the pin reset comes up in master mode
        repeat (8) @(posedge clk);
        chk("clockOe", {31'h0, cOe}, 32'h1);
        @(negedge clk);
        prevClk = cOut;
        n = 0;
        for (i = 0; i < 80; i = i + 1) begin
            @(negedge clk);
            if (cOut && !prevClk) begin
                n = n + 1;
            end
            prevClk = cOut;
        end
        chk("clockRises", n, 80 / (2 * `PCP_MCLK_HALF_CYC));
        @(posedge clk);
        rbCrcErr <= 1'b1;
        @(posedge clk);
        rbCrcErr <= 1'b0;
        repeat (3) @(posedge clk);
        chk("upsetOff", {31'h0, iOe}, 32'h0);
        upsetEn  <= 1'b1;
        rbCrcErr <= 1'b1;
        @(posedge clk);
        rbCrcErr <= 1'b0;
        repeat (3) @(posedge clk);
        chk("upsetOn", {31'h0, iOe}, 32'h1);
        chk("wordsLeft", expQ.size(), 32'h0);
        $display("test master done");
        tally_and_finish;
    end
endmodule
